// ===== src/tmc_pkg.sv
package tmc_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [3:0]  TMC_CTRL_OFS   = 4'h0;
	localparam logic [3:0]  TMC_COUNT_OFS  = 4'h4;
	localparam logic [3:0]  TMC_STATUS_OFS = 4'h8;
	localparam logic [15:0] TMC_CTRL_RST   = 16'h0000;
	localparam logic [15:0] TMC_CTRL_MASK  = 16'hA376;
	localparam logic [1:0]  TMC_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  TMC_RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// control field positions
	// ------------------------------------------------------------
	localparam int TMC_BIT_RUN   = 15;
	localparam int TMC_BIT_IDLE  = 13;
	localparam int TMC_BIT_ESRC  = 8;
	localparam int TMC_BIT_GATE  = 6;
	localparam int TMC_BIT_PS    = 4;
	localparam int TMC_BIT_SYNC  = 2;
	localparam int TMC_BIT_CSRC  = 1;

	// ------------------------------------------------------------
	// encodings and counts
	// ------------------------------------------------------------
	localparam logic [1:0] TMC_ESRC_SEC_OSC = 2'h0;
	localparam logic [1:0] TMC_ESRC_PIN     = 2'h1;
	localparam logic [1:0] TMC_ESRC_LP_RC   = 2'h2;
	localparam logic [1:0] TMC_ESRC_GEN   = 2'h3;
	localparam logic [7:0] TMC_DIV1_M     = 8'h00;
	localparam logic [7:0] TMC_DIV8_M     = 8'h07;
	localparam logic [7:0] TMC_DIV64_M    = 8'h3F;
	localparam logic [7:0] TMC_DIV256_M   = 8'hFF;
	// internal instruction clock is the system clock divided by two
	localparam logic [0:0] TMC_INST_DIV_M = 1'h1;

	typedef struct packed {
		logic       run;
		logic       idle_stop;
		logic [1:0] ext_src;
		logic       gate_acc;
		logic [1:0] prescale;
		logic       ext_sync;
		logic       clk_src;
	} tmc_ctrl_t;

	typedef struct packed {
		logic secondary_oscillator;
		logic low_power_rc_oscillator;
		logic pin;
		logic gen;
	} tmc_ext_t;
endpackage

// ===== src/tmc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_prescaler (
	input  wire logic       aclk,     // system clock
	input  wire logic       aresetn,  // sync reset, active low
	input  wire logic       tick_in,  // selected source tick
	input  wire logic [1:0] sel,      // prescale select
	output logic            tick_out  // divided tick
);
	import tmc_pkg::*;

	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic [7:0] mask;

	// ------------------------------------------------------------
	// ratio decode
	// ------------------------------------------------------------
	assign mask = (sel == 2'h3) ? TMC_DIV256_M :
	              (sel == 2'h2) ? TMC_DIV64_M  :
	              (sel == 2'h1) ? TMC_DIV8_M   : TMC_DIV1_M;     // [RULE6]
	assign tick_out = tick_in && ((cnt_q & mask) == mask);    // [RULE6]
	assign cnt_d    = tick_out ? 8'h00 : cnt_q + 8'h01;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_q <= 8'h00;
		else if (tick_in)
			cnt_q <= cnt_d;
	end
endmodule
`default_nettype wire

// ===== src/tmc_timer.sv
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1 - the run bit 15 starts the 16-bit counter and clearing it stops it.
// RULE2 - with idle-stop bit 13 set the counter halts in idle, else it keeps running.
// RULE3 - unimplemented control bits, bit 7 among them, ignore writes and read zero.
// RULE4 - bits 9-8 pick the external source: 11 generic, 10 rc osc, 01 own pin, 00 secondary.
// RULE5 - gate bit 6 enables gated accumulation on the internal clock only.
// RULE6 - the prescale field divides the source by 256, 64, 8 or 1.
// RULE7 - the sync bit synchronises the external clock, only with external source.
// RULE8 - source select 1 takes the extended source, 0 the system clock over two.
// RULE9 - gated accumulation counts prescaled ticks only while the gate is high.
module tmc_timer (
	input  wire logic          aclk,          // 200 MHz system clock
	input  wire logic          aresetn,       // sync reset, active low
	input  wire logic          idle_mode,     // device idle state
	input  wire tmc_pkg::tmc_ext_t ext_clk,   // external clock sources
	input  wire logic          gate_in,       // gate input pin
	input  wire logic [3:0]    s_axi_awaddr,  // write address
	input  wire logic          s_axi_awvalid, // write address valid
	output logic               s_axi_awready, // write address ready
	input  wire logic [31:0]   s_axi_wdata,   // write data
	input  wire logic [3:0]    s_axi_wstrb,   // write strobes
	input  wire logic          s_axi_wvalid,  // write data valid
	output logic               s_axi_wready,  // write data ready
	output logic [1:0]         s_axi_bresp,   // write response
	output logic               s_axi_bvalid,  // write response valid
	input  wire logic          s_axi_bready,  // write response ready
	input  wire logic [3:0]    s_axi_araddr,  // read address
	input  wire logic          s_axi_arvalid, // read address valid
	output logic               s_axi_arready, // read address ready
	output logic [31:0]        s_axi_rdata,   // read data
	output logic [1:0]         s_axi_rresp,   // read response
	output logic               s_axi_rvalid,  // read valid
	input  wire logic          s_axi_rready,  // read ready
	output logic [15:0]        count,         // counter value
	output logic               count_tick     // counter advanced
);
	import tmc_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [15:0] ctrl_q;
	logic [15:0] count_q;
	logic        aw_q;
	logic [3:0]  awaddr_q;
	logic        w_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic        inst_q;
	logic        ext_prev_q;
	logic        sync1_q;
	logic        sync2_q;
	logic        sync_prev_q;
	tmc_ctrl_t   cf;

	// ------------------------------------------------------------
	// control fields
	// ------------------------------------------------------------
	assign cf.run       = ctrl_q[TMC_BIT_RUN];
	assign cf.idle_stop = ctrl_q[TMC_BIT_IDLE];
	assign cf.ext_src   = ctrl_q[TMC_BIT_ESRC +: 2];
	assign cf.gate_acc  = ctrl_q[TMC_BIT_GATE];
	assign cf.prescale  = ctrl_q[TMC_BIT_PS +: 2];
	assign cf.ext_sync  = ctrl_q[TMC_BIT_SYNC];
	assign cf.clk_src   = ctrl_q[TMC_BIT_CSRC];

	// ------------------------------------------------------------
	// source selection
	// ------------------------------------------------------------
	logic ext_raw;
	logic ext_used;
	logic ext_rise;
	logic inst_tick;
	logic src_tick;
	logic ps_tick;
	logic gate_ok;
	logic halt;
	logic adv;

	assign ext_raw =
		(cf.ext_src == TMC_ESRC_GEN)   ? ext_clk.gen :
		(cf.ext_src == TMC_ESRC_LP_RC) ? ext_clk.low_power_rc_oscillator :
		(cf.ext_src == TMC_ESRC_PIN)   ? ext_clk.pin :
		                                 ext_clk.secondary_oscillator;        // [RULE4]
	// unsynchronised mode edge-detects the raw pin level directly: no metastability
	// filter, two cycles less latency
	assign ext_used  = cf.ext_sync ? sync2_q : ext_raw;                  // [RULE7]
	assign ext_rise  = ext_used && !(cf.ext_sync ? sync_prev_q : ext_prev_q);
	assign inst_tick = (inst_q == TMC_INST_DIV_M);
	assign src_tick  = cf.clk_src ? ext_rise : inst_tick;                // [RULE8]
	// gate only matters on the internal clock
	assign gate_ok   = cf.clk_src || !cf.gate_acc || gate_in;            // [RULE5] [RULE9]
	assign halt      = cf.idle_stop && idle_mode;                        // [RULE2]
	assign adv       = cf.run && !halt && ps_tick && gate_ok;            // [RULE1]

	tmc_prescaler u_ps (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.tick_in  (src_tick && cf.run && !halt),
		.sel      (cf.prescale),
		.tick_out (ps_tick)
	);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			inst_q      <= 1'b0;
			ext_prev_q  <= 1'b0;
			sync1_q     <= 1'b0;
			sync2_q     <= 1'b0;
			sync_prev_q <= 1'b0;
			count_q     <= 16'h0000;
		end
		else
		begin
			inst_q      <= inst_q + 1'b1;
			ext_prev_q  <= ext_raw;
			sync1_q     <= ext_raw;
			sync2_q     <= sync1_q;
			sync_prev_q <= sync2_q;
			if (adv)
				count_q <= count_q + 16'h0001;                       // [RULE1] [RULE9]
		end
	end

	assign count      = count_q;
	assign count_tick = adv;

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	logic        do_wr;
	logic [31:0] wmask;
	logic [15:0] ctrl_new;
	logic        wr_hit;
	logic        rd_ctrl;
	logic        rd_cnt;
	logic        rd_stat;
	logic        do_rd;

	assign s_axi_awready = !aw_q && !bvalid_q;
	assign s_axi_wready  = !w_q && !bvalid_q;
	assign do_wr  = aw_q && w_q && !bvalid_q;
	assign wmask  = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign wr_hit = (awaddr_q == TMC_CTRL_OFS);
	// unimplemented bits are never stored, so they read back zero
	assign ctrl_new = ((ctrl_q & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]))
	                  & TMC_CTRL_MASK;                                   // [RULE3]
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	assign s_axi_arready = !rvalid_q;
	assign do_rd   = s_axi_arvalid && !rvalid_q;
	assign rd_ctrl = (s_axi_araddr == TMC_CTRL_OFS);
	assign rd_cnt  = (s_axi_araddr == TMC_COUNT_OFS);
	assign rd_stat = (s_axi_araddr == TMC_STATUS_OFS);
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_q     <= 1'b0;
			awaddr_q <= 4'h0;
			w_q      <= 1'b0;
			wdata_q  <= 32'h00000000;
			wstrb_q  <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q  <= TMC_RESP_OKAY;
			ctrl_q   <= TMC_CTRL_RST;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_q     <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_q     <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_wr)
			begin
				aw_q     <= 1'b0;
				w_q      <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= wr_hit ? TMC_RESP_OKAY : TMC_RESP_SLVERR;
				if (wr_hit)
					ctrl_q <= ctrl_new;
			end
			else if (bvalid_q && s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= TMC_RESP_OKAY;
		end
		else if (do_rd)
		begin
			rvalid_q <= 1'b1;
			rresp_q  <= (rd_ctrl || rd_cnt || rd_stat) ? TMC_RESP_OKAY : TMC_RESP_SLVERR;
			rdata_q  <= rd_ctrl ? {16'h0000, ctrl_q} :                       // [RULE3]
			            rd_cnt  ? {16'h0000, count_q} :
			            rd_stat ? {29'h00000000, halt, gate_in, ext_used} : 32'h00000000;
		end
		else if (rvalid_q && s_axi_rready)
			rvalid_q <= 1'b0;
	end
endmodule
`default_nettype wire

// ===== dv/tmc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_properties
	import tmc_pkg::*;
(
	input wire logic        aclk,          // clock
	input wire logic        aresetn,       // reset
	input wire logic        s_axi_awvalid, // aw valid
	input wire logic        s_axi_awready, // aw ready
	input wire logic        s_axi_wvalid,  // w valid
	input wire logic        s_axi_wready,  // w ready
	input wire logic        s_axi_bvalid,  // b valid
	input wire logic        s_axi_arvalid, // ar valid
	input wire logic        s_axi_arready, // ar ready
	input wire logic [3:0]  s_axi_araddr,  // ar addr
	input wire logic        s_axi_rvalid,  // r valid
	input wire logic [31:0] s_axi_rdata,   // r data
	input wire logic [1:0]  s_axi_rresp,   // r resp
	input wire logic [15:0] count,         // counter
	input wire logic        count_tick     // step
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ----
	// bus and counter
	// ----
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_at(logic [3:0] a);
		s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
	endsequence
	property p_step; count_tick |=> count == $past(count) + 16'h1; endproperty
	a_step: assert property (p_step) else $error("no step");
	property p_hold; !count_tick |=> $stable(count); endproperty
	a_hold: assert property (p_hold) else $error("count moved");
	property p_gap; count_tick |=> !count_tick; endproperty
	a_gap: assert property (p_gap) else $error("ticks too close");
	property p_wr; s_wr_both |-> ##2 s_axi_bvalid; endproperty
	a_wr: assert property (p_wr) else $error("no write answer");
	property p_bad; s_rd_at(4'hC) |=> s_axi_rvalid && s_axi_rresp == TMC_RESP_SLVERR
		&& s_axi_rdata == 32'h0; endproperty
	a_bad: assert property (p_bad) else $error("unmapped read");
	property p_unimp; s_rd_at(TMC_CTRL_OFS) |=> s_axi_rvalid
		&& (s_axi_rdata & ~{16'h0, TMC_CTRL_MASK}) == 32'h0; endproperty
	a_unimp: assert property (p_unimp) else $error("unused bit set");
	property p_wrefuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_wrefuse: assert property (p_wrefuse) else $error("write not refused");
	property p_rrefuse; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_rrefuse: assert property (p_rrefuse) else $error("read not refused");
endmodule
bind tmc_timer tmc_properties tmc_properties_inst (.*);
`default_nettype wire

// ===== dv/tmc_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_src_model
	import tmc_pkg::*;
(
	input  wire logic        aclk,      // clock
	input  wire logic [1:0]  sel,       // burst source
	input  wire logic        noise,     // others chatter
	input  wire logic        burst_go,  // load a new burst
	input  wire logic [15:0] burst_len, // rising edges in the burst
	output var  tmc_ext_t    ext_clk    // source levels
);
	int              pend = 0;
	logic [3:0]      lv = 4'h0;
	wire logic [1:0] k = {~sel[0], ~sel[1]};
	assign ext_clk = lv;
	// unpicked sources chatter so a wrong pick shows as extra counts
	always @(posedge aclk)
	begin
		for (int i = 0; i < 4; i++)
			lv[i] <= noise ? ~lv[i] : 1'b0;
		lv[k] <= pend > 0 && !lv[k];
		if (burst_go)
			pend <= int'(burst_len);
		else if (pend > 0 && !lv[k])
			pend <= pend - 1;
	end
endmodule
`default_nettype wire

// ===== dv/timer_one_control_clocking_test.sv
`timescale 1ns/1ps
`default_nettype none
module timer_one_control_clocking_test;
	import tmc_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn, idle_mode, gate_in, noise, count_tick, burst_go;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  sel, s_axi_bresp, s_axi_rresp;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [15:0] count, c0, burst_len;
	logic [31:0] s_axi_wdata, s_axi_rdata, q, v, seed = 32'h0000_9E9C;
	tmc_ext_t    ext_clk;
	int          mismatches = 0, checks_done = 0, exp_cnt;
	int          dv[4] = '{1, 8, 64, 256};
	always #2.5 aclk = ~aclk;
	tmc_timer tmc_timer_inst (.*);
	tmc_src_model tmc_src_model_inst (.*);
	// ----
	// tasks
	// ----
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (e !== g)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic report_and_stop();
		if (mismatches == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// one transfer; handshakes judged at the falling edge, where all is settled
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int         n;
		logic       ta, tw, tr;
		logic [1:0] r;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
		{s_axi_arvalid, s_axi_rready} <= {2{!w}};
		for (n = 0; n < 50; n++)
		begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
			tw = s_axi_wvalid && s_axi_wready;
			tr = w ? s_axi_bvalid : s_axi_rvalid;
			r = w ? s_axi_bresp : s_axi_rresp;
			q = s_axi_rdata;
			@(posedge aclk);
			if (ta)
				{s_axi_awvalid, s_axi_arvalid} <= 2'h0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			if (tr)
				break;
		end
		{s_axi_bready, s_axi_rready} <= 2'h0;
		chk("resp", {30'h0, er}, {30'h0, r});
		if (n == 50)
		begin
			mismatches++;
			report_and_stop();
		end
	endtask
	task automatic win(input int cyc, input int e);
		@(negedge aclk);
		c0 = count;
		repeat (cyc) @(negedge aclk);
		chk("ticks", e, {16'h0, 16'(count - c0)});
		@(posedge aclk);
	endtask
	initial
	begin
		{aresetn, idle_mode, gate_in, noise, sel} = 6'h00;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
		s_axi_wstrb = 4'hF;
		{burst_go, burst_len} = 17'h0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		bus(0, TMC_CTRL_OFS, 0, TMC_RESP_OKAY);
		chk("ctrl", {16'h0, TMC_CTRL_RST}, q);
		bus(1, 4'hC, 32'hFFFF_FFFF, TMC_RESP_SLVERR);
		bus(0, 4'hC, 0, TMC_RESP_SLVERR);
		chk("unmapped", 0, q);
		repeat (4)
		begin
			v = rnd() & 32'hFFFF_7FFF;
			bus(1, TMC_CTRL_OFS, v, TMC_RESP_OKAY);
			bus(0, TMC_CTRL_OFS, 0, TMC_RESP_OKAY);
			chk("ctrl", v & TMC_CTRL_MASK, q);
		end
		// internal clock, sync bit set but ignored
		for (int k = 0; k < 4; k++)
		begin
			idle_mode <= k[0];
			bus(1, TMC_CTRL_OFS, 32'h8004 | k << 4 | (k / 2) << 13, TMC_RESP_OKAY);
			repeat (2 * dv[k] + 4) @(posedge aclk);
			win(8 * dv[k], k == 3 ? 0 : 4);
			bus(0, TMC_STATUS_OFS, 0, TMC_RESP_OKAY);
			chk("status", k == 3 ? 4 : 0, q);
		end
		idle_mode <= 1'b0;
		for (int g = 0; g < 2; g++)
		begin
			gate_in <= g[0];
			bus(1, TMC_CTRL_OFS, 32'h8040, TMC_RESP_OKAY);
			repeat (6) @(posedge aclk);
			win(8, g * 4);
			bus(0, TMC_STATUS_OFS, 0, TMC_RESP_OKAY);
			chk("status", g * 2, q);
		end
		bus(1, TMC_CTRL_OFS, 0, TMC_RESP_OKAY);
		win(40, 0);
		aresetn <= 1'b0;
		gate_in <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		exp_cnt = 0;
		// quiet sources while the pick changes, so no stray edge is counted
		for (int s = 0; s < 4; s++)
		begin
			noise <= 1'b0;
			sel <= s[1:0];
			bus(1, TMC_CTRL_OFS, 32'h8042 | s << 8 | s << 4 | (s % 2) << 2, TMC_RESP_OKAY);
			noise <= 1'b1;
			burst_len <= 16'(4 * dv[s]);
			burst_go <= 1'b1;
			@(posedge aclk);
			burst_go <= 1'b0;
			repeat (8 * dv[s] + 10) @(negedge aclk);
			exp_cnt += 4;
			chk("count", exp_cnt, {16'h0, count});
			@(posedge aclk);
		end
		bus(1, TMC_CTRL_OFS, 32'h0002, TMC_RESP_OKAY);
		burst_len <= 16'h0008;
		burst_go <= 1'b1;
		@(posedge aclk);
		burst_go <= 1'b0;
		repeat (30) @(posedge aclk);
		bus(0, TMC_COUNT_OFS, 0, TMC_RESP_OKAY);
		chk("count", exp_cnt, q);
		report_and_stop();
	end
endmodule
`default_nettype wire
